//--- cit_pkg.sv
// constants and types shared by the instruction timing decoder
package cit_pkg;

	// ========================================================
	// widths and field positions
	localparam int CIT_HW_W     = 16;
	localparam int CIT_LIST_W   = 8;
	localparam int CIT_CNT_W    = 4;
	localparam int CIT_LR_PC_B  = 8;
	localparam int CIT_LOAD_B   = 11;

	// ========================================================
	// cycle counts, zero wait-state memory
	localparam logic [3:0] CIT_CYC_NONE      = 4'h0;
	localparam logic [3:0] CIT_CYC_ONE       = 4'h1;
	localparam logic [3:0] CIT_CYC_BUS       = 4'h2;
	localparam logic [3:0] CIT_CYC_IOP       = 4'h1;
	localparam logic [3:0] CIT_CYC_BR_TAKEN  = 4'h2;
	localparam logic [3:0] CIT_CYC_BR_NOT    = 4'h1;
	localparam logic [3:0] CIT_CYC_BRANCH    = 4'h2;
	localparam logic [3:0] CIT_CYC_CALL      = 4'h3;
	localparam logic [3:0] CIT_CYC_EXCH      = 4'h2;
	localparam logic [3:0] CIT_CYC_PC_WRITE  = 4'h2;
	localparam logic [3:0] CIT_CYC_SYS       = 4'h3;
	localparam logic [3:0] CIT_CYC_SLEEP     = 4'h2;
	localparam logic [3:0] CIT_CYC_LIST_BASE = 4'h1;
	localparam logic [3:0] CIT_CYC_RET_BASE  = 4'h3;
	localparam logic [3:0] CIT_CYC_TRAP_END  = 4'h1;

	// ========================================================
	// instruction classes and sequencer states
	typedef enum logic [3:0] {
		CIT_C_ALU,
		CIT_C_MEM,
		CIT_C_LIST,
		CIT_C_POP_PC,
		CIT_C_BCOND,
		CIT_C_BRANCH,
		CIT_C_CALL,
		CIT_C_EXCH,
		CIT_C_PC_WRITE,
		CIT_C_SYS,
		CIT_C_SLEEP,
		CIT_C_TRAP,
		CIT_C_UNDEF
	} cit_class_e;

	typedef enum logic [1:0] {
		CIT_S_IDLE,
		CIT_S_EXEC,
		CIT_S_TRAP,
		CIT_S_SLEEP
	} cit_state_e;

endpackage

//--- cit_list_count.sv
// population count of a register list
`timescale 1ns/1ps

module cit_list_count #(
	parameter int WIDTH = 9,
	parameter int OUT_W = 4
) (
	// list in
	input  wire logic [WIDTH-1:0] bits_i,
	// count out
	output logic      [OUT_W-1:0] count_o
);

	// ========================================================
	// elaboration check
	if ((1 << OUT_W) <= WIDTH)
	begin : g_chk
		$error("cit_list_count: OUT_W too narrow for WIDTH");
	end

	// ========================================================
	// count
	always_comb
	begin
		count_o = '0;
		for (int i = 0; i < WIDTH; i++)
		begin
			count_o = count_o + OUT_W'(bits_i[i]);
		end
	end

endmodule // cit_list_count

//--- cit_timing_decoder.sv
// instruction decoder and execution-cycle sequencer of the core
`timescale 1ns/1ps
//
// Contract
// (RULE_01) counts hold for zero wait-state memory; wait states stretch them
// (RULE_02) accept the 16-bit set except zero-branches and predicate block
// (RULE_03) 32-bit set is call, three barriers, special register read/write
// (RULE_04) single load/store: two cycles on bus, one on I/O port
// (RULE_05) conditional branch: two cycles taken, one not taken
// (RULE_06) multi load/store and plain push/pop: one plus list length
// (RULE_07) push with link one plus N; pop with return three plus N
// (RULE_08) branch two, call three, register branch exchange two
// (RULE_09) moves, arithmetic, logic, shifts, extend, reverse, multiply: one
// (RULE_10) stack or pc relative address and stack adjust: one cycle
// (RULE_11) barriers and special register read/write take three cycles
// (RULE_12) sleep instructions cost two cycles, sleep time excluded
// (RULE_13) trap instructions last until the trap handling reports done
// (RULE_14) any other encoding raises a fault and is not executed

module cit_timing_decoder
	import cit_pkg::*;
#(
	parameter int LIST_W = CIT_LIST_W
) (
	// clock and reset
	input  wire logic                 clk_sys_i,
	input  wire logic                 rst_i,
	// instruction in
	input  wire logic                 instr_valid_i,
	input  wire logic [31:0]          instr_i,
	// execution context
	input  wire logic                 cond_pass_i,
	input  wire logic                 addr_iop_i,
	input  wire logic                 mem_wait_i,
	input  wire logic                 trap_done_i,
	input  wire logic                 wake_i,
	// status out
	output logic                      ready_o,
	output logic                      busy_o,
	output logic                      done_o,
	output logic [CIT_CNT_W-1:0]      cycles_o,
	output logic                      fault_o,
	output logic                      trap_o,
	output logic                      sleep_o
);

	// ========================================================
	// elaboration check
	if (LIST_W != CIT_LIST_W)
	begin : g_chk
		$error("cit_timing_decoder: register list is fixed at 8 bits");
	end

	// ========================================================
	// declarations
	logic [CIT_HW_W-1:0]  hw1;
	logic [CIT_HW_W-1:0]  hw2;
	logic                 is32;
	logic                 lr_pc_bit;
	logic [CIT_CNT_W-1:0] list_n;
	cit_class_e           dec_class;
	logic [CIT_CNT_W-1:0] dec_cnt;
	logic                 taken;
	cit_state_e           state;
	cit_state_e           next_state;
	logic [CIT_CNT_W-1:0] remain;
	logic [CIT_CNT_W-1:0] next_remain;
	logic                 sleep_pend;
	logic                 next_sleep_pend;
	logic [CIT_CNT_W-1:0] exec_cnt;

	assign hw1 = instr_i[15:0];
	assign hw2 = instr_i[31:16];
	assign is32 = (hw1[15:13] == 3'h7) && (hw1[12:11] != 2'h0);
	// only push/pop carry the link/pc bit in the list
	assign lr_pc_bit = (hw1[15:12] == 4'hB) && hw1[CIT_LR_PC_B];

	cit_list_count #(
		.WIDTH (LIST_W + 1),
		.OUT_W (CIT_CNT_W)
	) u_list_count (
		.bits_i  ({lr_pc_bit, hw1[LIST_W-1:0]}),
		.count_o (list_n)
	);

	// ========================================================
	// decode
	always_comb
	begin
		dec_class = CIT_C_UNDEF;
		if (is32)
		begin
			if (hw1[15:11] == 5'h1E && hw2[15:14] == 2'h3 && hw2[12])
				dec_class = CIT_C_CALL; // RULE_03
			else if (hw1[15:11] == 5'h1E && hw2[15:14] == 2'h2 && !hw2[12])
			begin
				if (hw1[10:5] == 6'h1C || hw1[10:4] == 7'h3E)
					dec_class = CIT_C_SYS; // RULE_03
				else if (hw1[10:4] == 7'h3B && hw2[7:4] >= 4'h4
						&& hw2[7:4] <= 4'h6)
					dec_class = CIT_C_SYS; // RULE_03
			end
		end
		else
		begin
			casez (hw1[15:8])
				8'b000?????, 8'b001?????, 8'b010000??:
					dec_class = CIT_C_ALU; // RULE_09
				8'b010001??:
				begin
					if (hw1[9:8] == 2'h3)
						dec_class = CIT_C_EXCH; // RULE_08
					else if (hw1[9:8] != 2'h1 && {hw1[7], hw1[2:0]} == 4'hF)
						dec_class = CIT_C_PC_WRITE;
					else
						dec_class = CIT_C_ALU; // RULE_09
				end
				8'b01001???, 8'b0101????, 8'b011?????, 8'b100?????:
					dec_class = CIT_C_MEM; // RULE_04
				8'b1010????, 8'b10110000:
					dec_class = CIT_C_ALU; // RULE_10
				8'b1011?0?1:
					dec_class = CIT_C_UNDEF; // RULE_02
				8'b10110010:
					dec_class = CIT_C_ALU; // RULE_09
				8'b1011?10?:
					dec_class = (hw1[CIT_LOAD_B] && hw1[CIT_LR_PC_B]) ?
						CIT_C_POP_PC : CIT_C_LIST; // RULE_06 RULE_07
				8'b10111010:
				begin
					if (hw1[7:6] != 2'h2)
						dec_class = CIT_C_ALU; // RULE_09
				end
				8'b10110110:
				begin
					if (hw1[7:5] == 3'h3 && hw1[3:0] == 4'h2)
						dec_class = CIT_C_ALU;
				end
				8'b10111110:
					dec_class = CIT_C_TRAP; // RULE_13
				8'b10111111:
				begin
					// nonzero mask is the predicate block, not supported
					if (hw1[3:0] == 4'h0)
					begin
						if (hw1[7:4] == 4'h2 || hw1[7:4] == 4'h3)
							dec_class = CIT_C_SLEEP; // RULE_12
						else
							dec_class = CIT_C_ALU;
					end
				end
				8'b1100????:
					dec_class = CIT_C_LIST; // RULE_06
				8'b1101????:
				begin
					if (hw1[11:8] == 4'hF)
						dec_class = CIT_C_TRAP; // RULE_13
					else if (hw1[11:8] != 4'hE)
						dec_class = CIT_C_BCOND; // RULE_05
				end
				8'b11100???:
					dec_class = CIT_C_BRANCH; // RULE_08
				default:
					dec_class = CIT_C_UNDEF; // RULE_14
			endcase
		end
	end

	// ========================================================
	// cycle count per class
	always_comb
	begin
		case (dec_class)
			CIT_C_ALU:      dec_cnt = CIT_CYC_ONE; // RULE_09 RULE_10
			CIT_C_MEM:      dec_cnt = addr_iop_i ? CIT_CYC_IOP
				: CIT_CYC_BUS; // RULE_04
			CIT_C_LIST:     dec_cnt = CIT_CYC_LIST_BASE + list_n; // RULE_06
			CIT_C_POP_PC:   dec_cnt = CIT_CYC_RET_BASE + list_n; // RULE_07
			CIT_C_BCOND:    dec_cnt = cond_pass_i ? CIT_CYC_BR_TAKEN
				: CIT_CYC_BR_NOT; // RULE_05
			CIT_C_BRANCH:   dec_cnt = CIT_CYC_BRANCH; // RULE_08
			CIT_C_CALL:     dec_cnt = CIT_CYC_CALL; // RULE_08
			CIT_C_EXCH:     dec_cnt = CIT_CYC_EXCH; // RULE_08
			CIT_C_PC_WRITE: dec_cnt = CIT_CYC_PC_WRITE;
			CIT_C_SYS:      dec_cnt = CIT_CYC_SYS; // RULE_11
			CIT_C_SLEEP:    dec_cnt = CIT_CYC_SLEEP; // RULE_12
			default:        dec_cnt = CIT_CYC_NONE;
		endcase
	end

	// ========================================================
	// sequencer
	// a wait state freezes issue and execution count, as the memory holds the core
	assign taken = instr_valid_i && ready_o && !mem_wait_i;

	always_comb
	begin
		next_state = state;
		next_remain = remain;
		next_sleep_pend = sleep_pend;
		if (taken)
		begin
			next_sleep_pend = (dec_class == CIT_C_SLEEP);
			if (dec_class == CIT_C_UNDEF)
				next_state = CIT_S_IDLE; // RULE_14
			else if (dec_class == CIT_C_TRAP)
				next_state = CIT_S_TRAP; // RULE_13
			else
			begin
				next_state = CIT_S_EXEC;
				next_remain = dec_cnt;
			end
		end
		else
		begin
			case (state)
				CIT_S_EXEC:
				begin
					if (!mem_wait_i) // RULE_01
					begin
						if (remain == CIT_CYC_ONE)
							next_state = sleep_pend ? CIT_S_SLEEP
								: CIT_S_IDLE; // RULE_12
						else
							next_remain = remain - CIT_CYC_ONE;
					end
				end
				CIT_S_TRAP:
				begin
					if (trap_done_i) // RULE_13
					begin
						next_state = CIT_S_EXEC;
						next_remain = CIT_CYC_TRAP_END;
					end
				end
				CIT_S_SLEEP:
				begin
					if (wake_i)
					begin
						next_state = CIT_S_IDLE;
						next_sleep_pend = 1'b0;
					end
				end
				default:
					next_state = CIT_S_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk_sys_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			state <= CIT_S_IDLE;
			remain <= CIT_CYC_NONE;
			sleep_pend <= 1'b0;
		end
		else
		begin
			state <= next_state;
			remain <= next_remain;
			sleep_pend <= next_sleep_pend;
		end
	end

	// ========================================================
	// registered status
	always_ff @(posedge clk_sys_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			ready_o <= 1'b1;
			busy_o <= 1'b0;
			done_o <= 1'b0;
			trap_o <= 1'b0;
			sleep_o <= 1'b0;
		end
		else
		begin
			ready_o <= (next_state == CIT_S_IDLE)
				|| (next_state == CIT_S_EXEC
				&& next_remain == CIT_CYC_ONE && !next_sleep_pend);
			busy_o <= (next_state == CIT_S_EXEC)
				|| (next_state == CIT_S_TRAP);
			done_o <= (next_state == CIT_S_EXEC)
				&& (next_remain == CIT_CYC_ONE);
			trap_o <= (next_state == CIT_S_TRAP);
			sleep_o <= (next_state == CIT_S_SLEEP);
		end
	end

	always_ff @(posedge clk_sys_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			cycles_o <= CIT_CYC_NONE;
			fault_o <= 1'b0;
		end
		else
		begin
			if (taken)
				cycles_o <= dec_cnt;
			fault_o <= taken && (dec_class == CIT_C_UNDEF); // RULE_14
		end
	end

	// ========================================================
	// checks
	default clocking cit_cb @(posedge clk_sys_i);
	endclocking
	default disable iff (rst_i);

	always_ff @(posedge clk_sys_i or posedge rst_i)
	begin
		if (rst_i)
			exec_cnt <= CIT_CYC_NONE;
		else if (taken)
			exec_cnt <= CIT_CYC_NONE;
		else if (busy_o && !mem_wait_i)
			exec_cnt <= exec_cnt + CIT_CYC_ONE;
	end

	AST_COUNT_MET: assert property ( // RULE_01
		(done_o && !mem_wait_i && !trap_o && cycles_o != CIT_CYC_NONE)
		|-> (exec_cnt + CIT_CYC_ONE == cycles_o))
		else $error("execution length differs from decoded count");

	AST_MEM_TIME: assert property ( // RULE_04
		(taken && dec_class == CIT_C_MEM)
		|=> (cycles_o == ($past(addr_iop_i) ? CIT_CYC_IOP : CIT_CYC_BUS))
			&& (done_o == $past(addr_iop_i)))
		else $error("load/store cycle count wrong");

	AST_BCOND_TIME: assert property ( // RULE_05
		(taken && dec_class == CIT_C_BCOND && cond_pass_i)
		|=> busy_o && !done_o ##1 ($past(mem_wait_i) || done_o))
		else $error("taken branch not two cycles");

	AST_LIST_TIME: assert property ( // RULE_06
		(taken && dec_class == CIT_C_LIST)
		|=> cycles_o == 4'h1 + $past(list_n))
		else $error("list transfer count wrong");

	AST_RET_TIME: assert property ( // RULE_07
		(taken && dec_class == CIT_C_POP_PC)
		|=> cycles_o == 4'h3 + $past(list_n) && busy_o && !done_o)
		else $error("pop with return count wrong");

	AST_CALL_TIME: assert property ( // RULE_08
		(taken && dec_class == CIT_C_CALL) ##1 !mem_wait_i [*2]
		|=> done_o)
		else $error("call not three cycles");

	AST_ONE_CYCLE: assert property ( // RULE_09
		(taken && dec_class == CIT_C_ALU) |=> done_o && ready_o)
		else $error("single-cycle op not done in one cycle");

	AST_SYS_TIME: assert property ( // RULE_11
		(taken && dec_class == CIT_C_SYS) |=> !done_o ##1 !done_o)
		else $error("barrier or special access too short");

	AST_SLEEP_ENTRY: assert property ( // RULE_12
		(taken && dec_class == CIT_C_SLEEP) ##1 !mem_wait_i [*2]
		|=> sleep_o && !ready_o)
		else $error("sleep not entered after two cycles");

	AST_TRAP_HOLD: assert property ( // RULE_13
		(trap_o && !trap_done_i) |=> trap_o && busy_o && !done_o)
		else $error("trap ended without done");

	AST_UNDEF_FAULT: assert property ( // RULE_14
		(taken && dec_class == CIT_C_UNDEF) |=> fault_o && !busy_o)
		else $error("undefined encoding executed");

	AST_NO_PREDICATE: assert property ( // RULE_02
		(taken && !is32 && hw1[15:8] == 8'hBF && hw1[3:0] != 4'h0)
		|=> fault_o)
		else $error("predicate block accepted");

	AST_WIDE_SET: assert property ( // RULE_03
		(taken && is32 && dec_class != CIT_C_CALL && dec_class != CIT_C_SYS)
		|=> fault_o)
		else $error("unsupported 32-bit encoding accepted");

endmodule // cit_timing_decoder

//--- cit_far_model.sv
// far-side model: memory wait states, wake source and trap handler
`timescale 1ns/1ps

module cit_far_model #(
	parameter int WAKE_DLY = 3,
	parameter int TRAP_DLY = 4
) (
	// clock and reset
	input  wire logic clk_sys_i,
	input  wire logic rst_i,
	// bench command
	input  wire logic stall_en_i,
	// core status
	input  wire logic sleep_i,
	input  wire logic trap_i,
	// answers to the core
	output logic      mem_wait_o,
	output logic      wake_o,
	output logic      trap_done_o
);
	logic [3:0] wait_cnt;

	// ========================================================
	// memory: zero wait-state unless stalls are asked for
	always_ff @(posedge clk_sys_i or posedge rst_i)
	begin
		if (rst_i)
			mem_wait_o <= 1'h0;
		else
			mem_wait_o <= stall_en_i & ~mem_wait_o;
	end

	// ========================================================
	// wake and trap handling after a fixed delay
	always_ff @(posedge clk_sys_i or posedge rst_i)
	begin
		if (rst_i)
			wait_cnt <= 4'h0;
		else if (sleep_i | trap_i)
			wait_cnt <= wait_cnt + 4'h1;
		else
			wait_cnt <= 4'h0;
	end

	// one-cycle answers; the core drops its level right after
	always_ff @(posedge clk_sys_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			wake_o      <= 1'h0;
			trap_done_o <= 1'h0;
		end
		else
		begin
			wake_o      <= sleep_i && wait_cnt == 4'(WAKE_DLY);
			trap_done_o <= trap_i && wait_cnt == 4'(TRAP_DLY);
		end
	end
endmodule // cit_far_model

//--- tb_top.sv
// self-checking bench of the instruction timing decoder
`timescale 1ns/1ps

module tb_top
	import cit_pkg::*;
;
	typedef struct packed {
		logic [31:0] ins;
		logic        cnd;
		logic        iop;
		logic [3:0]  cyc;
		logic        flt;
	} cit_row_s;

	logic                 clk_sys_i;
	logic                 rst_i;
	logic                 instr_valid_i;
	logic [31:0]          instr_i;
	logic                 cond_pass_i;
	logic                 addr_iop_i;
	logic                 mem_wait_i;
	logic                 trap_done_i;
	logic                 wake_i;
	logic                 stall_en;
	logic                 ready_o;
	logic                 busy_o;
	logic                 done_o;
	logic                 fault_o;
	logic                 trap_o;
	logic                 sleep_o;
	logic [CIT_CNT_W-1:0] cycles_o;
	logic [31:0]          exp;
	logic                 trap_seen;
	int                   error_cnt;
	int                   checks_done;
	int                   n;
	int                   c;

	cit_row_s rows [0:25] = '{
		'{32'h00002001, 1'h0, 1'h0, 4'h1, 1'h0},
		'{32'h00004348, 1'h0, 1'h0, 4'h1, 1'h0},
		'{32'h0000B001, 1'h0, 1'h0, 4'h1, 1'h0},
		'{32'h0000A001, 1'h0, 1'h0, 4'h1, 1'h0},
		'{32'h00006808, 1'h0, 1'h0, 4'h2, 1'h0},
		'{32'h00006808, 1'h0, 1'h1, 4'h1, 1'h0},
		'{32'h0000D000, 1'h1, 1'h0, 4'h2, 1'h0},
		'{32'h0000D000, 1'h0, 1'h0, 4'h1, 1'h0},
		'{32'h0000E000, 1'h0, 1'h0, 4'h2, 1'h0},
		'{32'h00004700, 1'h0, 1'h0, 4'h2, 1'h0},
		'{32'h00004788, 1'h0, 1'h0, 4'h2, 1'h0},
		'{32'hF800F000, 1'h0, 1'h0, 4'h3, 1'h0},
		'{32'h0000C806, 1'h0, 1'h0, 4'h3, 1'h0},
		'{32'h0000B401, 1'h0, 1'h0, 4'h2, 1'h0},
		'{32'h0000B503, 1'h0, 1'h0, 4'h4, 1'h0},
		'{32'h0000BD01, 1'h0, 1'h0, 4'h5, 1'h0},
		'{32'h8F5FF3BF, 1'h0, 1'h0, 4'h3, 1'h0},
		'{32'h8F4FF3BF, 1'h0, 1'h0, 4'h3, 1'h0},
		'{32'h8F6FF3BF, 1'h0, 1'h0, 4'h3, 1'h0},
		'{32'h8000F3EF, 1'h0, 1'h0, 4'h3, 1'h0},
		'{32'h8800F380, 1'h0, 1'h0, 4'h3, 1'h0},
		'{32'h0000B100, 1'h0, 1'h0, 4'h0, 1'h1},
		'{32'h4000E92D, 1'h0, 1'h0, 4'h0, 1'h1},
		'{32'h00004687, 1'h0, 1'h0, 4'h2, 1'h0},
		'{32'h0000BF08, 1'h0, 1'h0, 4'h0, 1'h1},
		'{32'h0000DE00, 1'h0, 1'h0, 4'h0, 1'h1}
	};

	initial
	begin
		clk_sys_i = 1'h0;
		forever #20 clk_sys_i = ~clk_sys_i;
	end

	cit_timing_decoder #(.LIST_W(CIT_LIST_W)) i_dut (
		.clk_sys_i(clk_sys_i), .rst_i(rst_i), .instr_valid_i(instr_valid_i),
		.instr_i(instr_i), .cond_pass_i(cond_pass_i), .addr_iop_i(addr_iop_i),
		.mem_wait_i(mem_wait_i), .trap_done_i(trap_done_i), .wake_i(wake_i),
		.ready_o(ready_o), .busy_o(busy_o), .done_o(done_o),
		.cycles_o(cycles_o), .fault_o(fault_o), .trap_o(trap_o),
		.sleep_o(sleep_o));

	cit_far_model i_far (
		.clk_sys_i(clk_sys_i), .rst_i(rst_i), .stall_en_i(stall_en),
		.sleep_i(sleep_o), .trap_i(trap_o), .mem_wait_o(mem_wait_i),
		.wake_o(wake_i), .trap_done_o(trap_done_i));

	task automatic end_of_test();
		$display("checks %0d errors %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] want);
		checks_done++;
		if (seen !== want)
		begin
			error_cnt++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, want);
		end
	endtask

	// bounded waits: a hang counts as a mismatch
	task automatic guard(input int k);
		if (k > 60)
		begin
			error_cnt++;
			$display("[FAIL] %0t wait ran out", $time);
			end_of_test();
		end
	endtask

	task automatic tick();
		@(posedge clk_sys_i);
		#1;
	endtask

	// offer held until taken, then cycles counted to done or fault
	task automatic run(input logic [31:0] ins, input logic cnd, iop);
		instr_i       = ins;
		cond_pass_i   = cnd;
		addr_iop_i    = iop;
		instr_valid_i = 1'h1;
		n = 0;
		while (!(ready_o === 1'h1 && mem_wait_i === 1'h0))
		begin
			tick();
			n++;
			guard(n);
		end
		tick();
		instr_valid_i = 1'h0;
		c = 1;
		while (done_o !== 1'h1 && fault_o !== 1'h1)
		begin
			if (trap_o === 1'h1)
				trap_seen = 1'h1;
			tick();
			c++;
			guard(c);
		end
	endtask

	initial
	begin
		error_cnt     = 0;
		checks_done   = 0;
		rst_i         = 1'h1;
		instr_valid_i = 1'h0;
		instr_i       = 32'h0;
		cond_pass_i   = 1'h0;
		addr_iop_i    = 1'h0;
		stall_en      = 1'h0;
		trap_seen     = 1'h0;
		repeat (10) @(posedge clk_sys_i);
		#1;
		check({26'h0, ready_o, busy_o, done_o, fault_o, trap_o, sleep_o},
			32'h20);
		check({28'h0, cycles_o}, 32'h0);
		rst_i = 1'h0;
		// ========================================================
		// table rows, issued back to back
		foreach (rows[i])
		begin
			run(rows[i].ins, rows[i].cnd, rows[i].iop);
			exp = rows[i].flt ? 32'h1 : {28'h0, rows[i].cyc};
			check(32'(c), exp);
			check({31'h0, fault_o}, {31'h0, rows[i].flt});
			check({28'h0, cycles_o}, {28'h0, rows[i].cyc});
			if (rows[i].flt)
				check({31'h0, busy_o}, 32'h0);
		end
		// ========================================================
		// wait states stretch a bus load
		stall_en = 1'h1;
		run(32'h00006808, 1'h0, 1'h0);
		check({31'h0, c > 2}, 32'h1);
		check({28'h0, cycles_o}, 32'h2);
		stall_en = 1'h0;
		// ========================================================
		// sleep instructions, woken by the far side
		for (int k = 0; k < 2; k++)
		begin
			run(k ? 32'h0000BF20 : 32'h0000BF30, 1'h0, 1'h0);
			check(32'(c), 32'h2);
			tick();
			check({30'h0, sleep_o, ready_o}, 32'h2);
			n = 0;
			while (sleep_o === 1'h1)
			begin
				tick();
				n++;
				guard(n);
			end
			check({31'h0, ready_o}, 32'h1);
		end
		// ========================================================
		// traps last until the handler reports done
		for (int k = 0; k < 2; k++)
		begin
			trap_seen = 1'h0;
			run(k ? 32'h0000DF00 : 32'h0000BE00, 1'h0, 1'h0);
			check({29'h0, trap_seen, busy_o, fault_o}, 32'h6);
			check({28'h0, cycles_o}, 32'h0);
			// handler answers five cycles in, plus entry and end cycles
			check(32'(c), 32'h7);
			tick();
		end
		// ========================================================
		// reset in mid-instruction, then recovery
		instr_i       = 32'h0000BD01;
		instr_valid_i = 1'h1;
		tick();
		instr_valid_i = 1'h0;
		tick();
		check({31'h0, busy_o}, 32'h1);
		rst_i = 1'h1;
		#1;
		check({29'h0, ready_o, busy_o, done_o}, 32'h4);
		tick();
		rst_i = 1'h0;
		run(32'h00002001, 1'h0, 1'h0);
		check(32'(c), 32'h1);
		end_of_test();
	end
endmodule // tb_top
